// ---- core/hbi_pkg.sv ----
`default_nettype none
package hbi_pkg;

  localparam int          HBI_AW        = 15;   // host address lines 15..1
  localparam int          HBI_DW        = 32;
  localparam int          HBI_BASE_W    = 12;   // host address lines 15..4
  localparam int          HBI_IDX_W     = 3;    // host address lines 3..1
  localparam int          HBI_SYNC_W    = 4;

  // byte-enable patterns, bit n is byte enable n, active low
  localparam logic [3:0]  HBI_BE_DWORD  = 4'h0;
  localparam logic [3:0]  HBI_BE_LOW16  = 4'hC;
  localparam logic [3:0]  HBI_BE_HIGH16 = 4'h3;
  localparam logic [3:0]  HBI_BE_BYTE0  = 4'hE;
  localparam logic [3:0]  HBI_BE_BYTE1  = 4'hD;
  localparam logic [3:0]  HBI_BE_BYTE2  = 4'hB;
  localparam logic [3:0]  HBI_BE_BYTE3  = 4'h7;

  // lane masks, bit n selects data lines 8n+7..8n
  localparam logic [3:0]  HBI_LN_NONE   = 4'h0;
  localparam logic [3:0]  HBI_LN_ALL    = 4'hF;
  localparam logic [3:0]  HBI_LN_LOW16  = 4'h3;
  localparam logic [3:0]  HBI_LN_HIGH16 = 4'hC;
  localparam logic [3:0]  HBI_LN_B0     = 4'h1;
  localparam logic [3:0]  HBI_LN_B1     = 4'h2;
  localparam logic [3:0]  HBI_LN_B2     = 4'h4;
  localparam logic [3:0]  HBI_LN_B3     = 4'h8;

  // bit positions inside the synchronised pin vector
  localparam int          HBI_S_ADS     = 0;
  localparam int          HBI_S_RD      = 1;
  localparam int          HBI_S_WR      = 2;
  localparam int          HBI_S_CS      = 3;

  typedef enum logic [2:0] {
    HBI_IDLE, HBI_ASYNC, HBI_ASYNC_END, HBI_VLB, HBI_VLB_RTN, HBI_BURST, HBI_BURST_BEAT
  } hbi_state_t;

  // internal register/queue access request, one-cycle req pulse
  typedef struct packed {
    logic                   req;
    logic                   we;
    logic                   data_port;
    logic [HBI_IDX_W-1:0]   idx;
    logic [3:0]             lanes;
    logic [HBI_DW-1:0]      wdata;
  } hbi_req_t;

  // internal answer: ack pulse with read data
  typedef struct packed {
    logic                   ack;
    logic [HBI_DW-1:0]      rdata;
  } hbi_rsp_t;

endpackage : hbi_pkg
`default_nettype wire

// ---- core/hbi_pin_sync.sv ----
`default_nettype none
module hbi_pin_sync
  import hbi_pkg::*;
#(
  parameter int W = HBI_SYNC_W
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] pin,
  output logic      [W-1:0] level
);
  // stage one is read only by stage two; level moves once stages two and three agree
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] lvl;
  } hbi_sync_st_t;

  hbi_sync_st_t sy_q;
  hbi_sync_st_t sy_d;

  always_comb begin
    sy_d    = sy_q;
    sy_d.s1 = pin;
    sy_d.s2 = sy_q.s1;
    sy_d.s3 = sy_q.s2;
    for (int i = 0; i < W; i++) begin
      if (sy_q.s2[i] == sy_q.s3[i]) begin
        sy_d.lvl[i] = sy_q.s3[i];
      end
    end
  end

  // strobes are active low, so reset parks every stage at the idle level
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sy_q <= '1;
    end else begin
      sy_q <= sy_d;
    end
  end

  assign level = sy_q.lvl;
endmodule : hbi_pin_sync
`default_nettype wire

// ---- core/hbi_host_bus_unit.sv ----
// Summary of operation
// RULE1: only byte enable 2 low selects a byte on data lines 23..16.
// RULE2: only byte enable 3 low selects a byte on data lines 31..24.
// RULE3: other patterns give dword, low half, high half, byte 0, byte 1.
// RULE4: byte enables are ignored while the data port select is low. The code ignores them only on the 32-bit bus.
// RULE5: lines 31..16 are used only in the 32-bit configuration.
// RULE6: address, qualifier and byte enables are captured at address strobe rise.
// RULE7: target hit decodes the qualifier and address 15..4 against the base address.
// RULE8: target hit is asserted whenever the unit is addressed, sync or async.
// RULE9: local decode is enabled only while the I/O qualifier is low.
// RULE10: data port select bypasses decode and forces a 32-bit data port access. The code ignores the select on the 16-bit bus.
// RULE11: strap 0 runs single VL-style cycles, strap 1 runs burst cycles.
// RULE12: in VL-style mode direction is sampled when cycle qualify is asserted.
// RULE13: in burst mode cycle qualify low is the burst write indication.
// RULE14: in VL-style mode host drives direction high to write, low to read.
// RULE15: in burst mode direction low is the burst read indication.
// RULE16: in VL-style mode sync ready behaves as the VL bus slave ready.
// RULE17: in burst mode sync ready inserts wait states until data is done.
// RULE18: in VL-style mode host asserts ready return to end the cycle.
// RULE19: in burst mode host holds ready return low to insert its waits.
// RULE20: async wait output stays low while the unit stretches an async transfer.
// RULE21: all synchronous pins are sampled and driven on the bus clock rise.
`default_nettype none
module hbi_host_bus_unit
  import hbi_pkg::*;
(
  input  wire logic                  clk,
  input  wire logic                  rst,
  input  wire logic                  bus_is_32,
  input  wire logic                  bus_type_strap,
  input  wire logic [HBI_BASE_W-1:0] base_addr,
  input  wire logic [HBI_AW-1:0]     host_addr,
  input  wire logic                  io_qualify_n,
  input  wire logic                  byte_lane0_sel_n,
  input  wire logic                  byte_lane1_sel_n,
  input  wire logic                  byte_lane2_sel_n,
  input  wire logic                  byte_lane3_sel_n,
  input  wire logic                  addr_strobe_n,
  input  wire logic                  data_port_select_n,
  input  wire logic                  async_read_strobe_n,
  input  wire logic                  async_write_strobe_n,
  input  wire logic                  cycle_qualify_n,
  input  wire logic                  write_not_read,
  input  wire logic                  ready_return_in_n,
  input  wire logic [HBI_DW-1:0]     data_in,
  output logic      [HBI_DW-1:0]     data_out,
  output logic      [1:0]            data_oe,
  output logic                       local_target_hit_n,
  output logic                       sync_ready_out_n,
  output logic                       async_wait_out,
  output hbi_req_t                   host_req,
  input  wire hbi_rsp_t              host_rsp
);

  typedef struct packed {
    hbi_state_t            state;
    logic                  strap_taken;
    logic                  burst_mode;
    logic [HBI_AW-1:0]     addr;
    logic                  aen_n;
    logic [3:0]            be_n;
    logic                  hit_n;
    logic                  srdy_n;
    logic                  await;
    logic [HBI_DW-1:0]     rdata;
    logic [1:0]            oe;
    logic                  rd_prev;
    logic                  wr_prev;
    hbi_req_t              req;
  } hbi_st_t;

  // decoded byte lanes, zero when the pattern is not a legal access
  function automatic logic [3:0] hbi_lanes(input logic [3:0] be_n, input logic wide);
    logic [3:0] m;
    m = HBI_LN_NONE;
    if (be_n == HBI_BE_DWORD) begin
      m = HBI_LN_ALL;                                            // RULE3
    end else if (be_n == HBI_BE_LOW16) begin
      m = HBI_LN_LOW16;                                          // RULE3
    end else if (be_n == HBI_BE_HIGH16) begin
      m = HBI_LN_HIGH16;                                         // RULE3
    end else if (be_n == HBI_BE_BYTE0) begin
      m = HBI_LN_B0;                                             // RULE3
    end else if (be_n == HBI_BE_BYTE1) begin
      m = HBI_LN_B1;                                             // RULE3
    end else if (be_n == HBI_BE_BYTE2) begin
      m = HBI_LN_B2;                                             // RULE1
    end else if (be_n == HBI_BE_BYTE3) begin
      m = HBI_LN_B3;                                             // RULE2
    end
    // upper lanes only exist on the wide bus
    if (!wide && (m & HBI_LN_HIGH16) != HBI_LN_NONE) begin
      m = HBI_LN_NONE;                                           // RULE5
    end
    return m;
  endfunction : hbi_lanes

  logic [HBI_SYNC_W-1:0] pin_raw;
  logic [HBI_SYNC_W-1:0] pin_s;
  hbi_st_t               st_q;
  hbi_st_t               st_d;
  logic                  cs_act;
  logic                  rd_fall;
  logic                  wr_fall;
  logic [3:0]            lanes;
  logic                  target;
  logic                  burst_wr;
  logic                  burst_rd;

  assign pin_raw = {data_port_select_n, async_write_strobe_n, async_read_strobe_n, addr_strobe_n};

  hbi_pin_sync #(.W(HBI_SYNC_W)) u_sync (
    .clk   (clk),
    .rst   (rst),
    .pin   (pin_raw),
    .level (pin_s)
  );

  // chip select only exists on the wide bus
  assign cs_act   = !pin_s[HBI_S_CS] && bus_is_32;                // RULE10
  assign lanes    = cs_act ? HBI_LN_ALL : hbi_lanes(st_q.be_n, bus_is_32);  // RULE4
  assign target   = cs_act || (!st_q.hit_n && lanes != HBI_LN_NONE);
  assign rd_fall  = st_q.rd_prev && !pin_s[HBI_S_RD];
  assign wr_fall  = st_q.wr_prev && !pin_s[HBI_S_WR];
  assign burst_wr = !cycle_qualify_n;                             // RULE13
  assign burst_rd = !write_not_read;                              // RULE15

  always_comb begin
    st_d         = st_q;
    st_d.req.req = 1'b0;
    st_d.rd_prev = pin_s[HBI_S_RD];
    st_d.wr_prev = pin_s[HBI_S_WR];
    if (!st_q.strap_taken) begin
      st_d.strap_taken = 1'b1;
      st_d.burst_mode  = bus_type_strap;                          // RULE11
    end
    // transparent while strobe low, held from its rising edge
    if (!pin_s[HBI_S_ADS]) begin
      st_d.addr  = host_addr;                                     // RULE6
      st_d.aen_n = io_qualify_n;                                  // RULE6
      st_d.be_n  = {byte_lane3_sel_n, byte_lane2_sel_n, byte_lane1_sel_n, byte_lane0_sel_n};  // RULE6
    end
    // decode only for I/O cycles
    st_d.hit_n = !(!st_q.aen_n && st_q.addr[HBI_AW-1:HBI_IDX_W] == base_addr);  // RULE7 RULE8 RULE9
    case (st_q.state)
      HBI_IDLE: begin
        st_d.req.data_port = cs_act;
        st_d.req.idx       = st_q.addr[HBI_IDX_W-1:0];
        st_d.req.lanes     = lanes;
        st_d.req.wdata     = data_in;
        if ((rd_fall || wr_fall) && target) begin
          st_d.req.req = 1'b1;
          st_d.req.we  = wr_fall;
          st_d.await   = 1'b0;                                    // RULE20
          st_d.state   = HBI_ASYNC;
        end else if (st_q.strap_taken && !st_q.burst_mode && !cycle_qualify_n && target) begin
          st_d.req.req = 1'b1;
          st_d.req.we  = write_not_read;                          // RULE12 RULE14
          st_d.state   = HBI_VLB;
        end else if (st_q.strap_taken && st_q.burst_mode && (burst_wr || burst_rd) && target) begin
          st_d.req.req = 1'b1;
          st_d.req.we  = burst_wr;                                // RULE13 RULE15
          st_d.state   = HBI_BURST;
        end
      end
      HBI_ASYNC: begin
        if (host_rsp.ack) begin
          st_d.await = 1'b1;                                      // RULE20
          st_d.rdata = host_rsp.rdata;
          st_d.oe    = st_q.req.we ? 2'h0 : {bus_is_32, 1'b1};   // RULE5
          st_d.state = HBI_ASYNC_END;
        end
      end
      HBI_ASYNC_END: begin
        if (pin_s[HBI_S_RD] && pin_s[HBI_S_WR]) begin
          st_d.oe    = 2'h0;
          st_d.state = HBI_IDLE;
        end
      end
      HBI_VLB: begin
        if (host_rsp.ack) begin
          st_d.srdy_n = 1'b0;                                     // RULE16
          st_d.rdata  = host_rsp.rdata;
          st_d.oe     = st_q.req.we ? 2'h0 : {bus_is_32, 1'b1};  // RULE5
          st_d.state  = HBI_VLB_RTN;
        end
      end
      HBI_VLB_RTN: begin
        // read data held until the host returns ready
        if (!ready_return_in_n) begin
          st_d.srdy_n = 1'b1;                                     // RULE18
          st_d.oe     = 2'h0;
          st_d.state  = HBI_IDLE;
        end
      end
      HBI_BURST: begin
        if (host_rsp.ack) begin
          st_d.srdy_n = 1'b0;                                     // RULE17
          st_d.rdata  = host_rsp.rdata;
          st_d.oe     = st_q.req.we ? 2'h0 : {bus_is_32, 1'b1};  // RULE5
          st_d.state  = HBI_BURST_BEAT;
        end
      end
      HBI_BURST_BEAT: begin
        // host wait holds the beat and its data
        if (ready_return_in_n) begin
          st_d.srdy_n = 1'b1;                                     // RULE17 RULE19
          if ((burst_wr || burst_rd) && target) begin
            st_d.req.req   = 1'b1;
            st_d.req.we    = burst_wr;
            st_d.req.wdata = data_in;
            st_d.state     = HBI_BURST;
          end else begin
            st_d.oe    = 2'h0;
            st_d.state = HBI_IDLE;
          end
        end
      end
      default: begin
        st_d.state = HBI_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin                   // RULE21
    if (rst) begin
      st_q <= '{state: HBI_IDLE, strap_taken: 1'b0, burst_mode: 1'b0, addr: '0, aen_n: 1'b1,
                be_n: '1, hit_n: 1'b1, srdy_n: 1'b1, await: 1'b1, rdata: '0, oe: 2'h0,
                rd_prev: 1'b1, wr_prev: 1'b1, req: '0};
    end else begin
      st_q <= st_d;
    end
  end

  assign data_out           = st_q.rdata;
  assign data_oe            = st_q.oe;
  assign local_target_hit_n = st_q.hit_n;
  assign sync_ready_out_n   = st_q.srdy_n;
  assign async_wait_out     = st_q.await;
  assign host_req           = st_q.req;

  a_byte2_lane: assert property (@(posedge clk) disable iff (rst)
    (st_q.req.req && !st_q.req.data_port && $past(st_q.be_n) == HBI_BE_BYTE2)
      |-> st_q.req.lanes == HBI_LN_B2) else $error("byte 2 lane wrong");  // RULE1
  a_byte3_lane: assert property (@(posedge clk) disable iff (rst)
    (st_q.req.req && !st_q.req.data_port && $past(st_q.be_n) == HBI_BE_BYTE3)
      |-> st_q.req.lanes == HBI_LN_B3) else $error("byte 3 lane wrong");  // RULE2
  a_lane_dword: assert property (@(posedge clk) disable iff (rst)
    (st_q.req.req && !st_q.req.data_port && $past(st_q.be_n) == HBI_BE_DWORD)
      |-> st_q.req.lanes == HBI_LN_ALL) else $error("dword lanes wrong");  // RULE3
  a_latch_hold: assert property (@(posedge clk) disable iff (rst)
    pin_s[HBI_S_ADS] |=> ($stable(st_q.addr) && $stable(st_q.aen_n) && $stable(st_q.be_n)))
    else $error("address latch moved while strobe high");                // RULE6
  a_cs_dword: assert property (@(posedge clk) disable iff (rst)
    (st_q.req.req && st_q.req.data_port) |-> st_q.req.lanes == HBI_LN_ALL)
    else $error("data port access not 32-bit");                           // RULE4 RULE10
  a_narrow_bus: assert property (@(posedge clk) disable iff (rst)
    !bus_is_32 |=> (!st_q.oe[1] && (!st_q.req.req || st_q.req.lanes[3:2] == 2'h0)))
    else $error("upper half used on 16-bit bus");                         // RULE5
  a_hit_decode: assert property (@(posedge clk) disable iff (rst)
    (!st_q.aen_n && st_q.addr[HBI_AW-1:HBI_IDX_W] == base_addr) |=> !local_target_hit_n)
    else $error("target hit missed");                                      // RULE7 RULE8
  a_dma_no_hit: assert property (@(posedge clk) disable iff (rst)
    st_q.aen_n |=> local_target_hit_n) else $error("hit during memory cycle");  // RULE9

  sequence s_vlb_return;
    st_q.state == HBI_VLB_RTN && !ready_return_in_n;
  endsequence
  sequence s_cycle_closed;
    sync_ready_out_n && data_oe == 2'h0;
  endsequence
  sequence s_beat_held;
    st_q.state == HBI_BURST_BEAT && !ready_return_in_n;
  endsequence

  a_vlb_dir: assert property (@(posedge clk) disable iff (rst)
    (st_q.state == HBI_IDLE && st_d.state == HBI_VLB) |=> st_q.req.we == $past(write_not_read))
    else $error("direction not sampled");                                 // RULE12
  a_vlb_hold: assert property (@(posedge clk) disable iff (rst)
    (st_q.state == HBI_VLB_RTN && ready_return_in_n) |=> (!sync_ready_out_n && $stable(data_out)))
    else $error("ready dropped before return");                           // RULE16 RULE18
  a_vlb_end: assert property (@(posedge clk) disable iff (rst)
    s_vlb_return |=> s_cycle_closed)
    else $error("cycle not ended on return");                             // RULE16
  a_burst_wait: assert property (@(posedge clk) disable iff (rst)
    (st_q.state == HBI_BURST && !host_rsp.ack) |=> sync_ready_out_n)
    else $error("burst ready without data");                              // RULE17
  a_burst_hold: assert property (@(posedge clk) disable iff (rst)
    s_beat_held |=> (!sync_ready_out_n && st_q.state == HBI_BURST_BEAT))
    else $error("beat ended during host wait");                           // RULE19
  a_async_wait: assert property (@(posedge clk) disable iff (rst)
    (st_q.state == HBI_ASYNC) |-> !async_wait_out) else $error("async wait released early");  // RULE20
  a_async_rel: assert property (@(posedge clk) disable iff (rst)
    (st_q.state == HBI_ASYNC && host_rsp.ack) |=> async_wait_out ##1 async_wait_out)
    else $error("async wait not released");                               // RULE20
  a_async_req: assert property (@(posedge clk) disable iff (rst)
    (st_q.state == HBI_IDLE && st_d.state == HBI_ASYNC) |=> (!async_wait_out && st_q.req.req))
    else $error("async wait not raised at start");                        // RULE20
  a_strap_mode: assert property (@(posedge clk) disable iff (rst)
    (st_q.burst_mode && st_q.state == HBI_IDLE) |=> st_q.state != HBI_VLB)
    else $error("single cycle in burst mode");                            // RULE11

endmodule : hbi_host_bus_unit
`default_nettype wire

// ---- verif/hbi_int_model.sv ----
`default_nettype none
module hbi_int_model
  import hbi_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire hbi_req_t    req,
  input  wire logic [3:0]  delay,
  input  wire logic [31:0] word,
  output var  hbi_rsp_t    rsp
);
  timeunit 1ns;
  timeprecision 1ps;
  logic       busy;
  logic [3:0] cnt;
  // read data is only meaningful with ack, so it shows the inverse in between
  always @(negedge clk or posedge rst) begin
    if (rst) begin
      busy <= 1'b0;
      cnt  <= 4'h0;
      rsp  <= '0;
    end else begin
      rsp.ack   <= 1'b0;
      rsp.rdata <= ~word;
      if (req.req) begin
        busy <= 1'b1;
        cnt  <= delay;
      end else if (busy && cnt == 4'h0) begin
        busy      <= 1'b0;
        rsp.ack   <= 1'b1;
        rsp.rdata <= word;
      end else if (busy) begin
        cnt <= cnt - 4'h1;
      end
    end
  end
endmodule : hbi_int_model
`default_nettype wire

// ---- verif/tb.sv ----
`default_nettype none
module tb;
  import hbi_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [11:0] BASE = 12'hA5C;
  localparam logic [31:0] WORD = 32'hC3A5_5A3C;
  logic        clk = 0, rst = 1, bus_is_32 = 1, bus_type_strap = 0;
  logic [14:0] host_addr = {BASE, 3'h2};
  logic [3:0]  be_n = 4'hF;
  logic        io_qualify_n = 0, addr_strobe_n = 0, data_port_select_n = 1;
  logic        async_read_strobe_n = 1, async_write_strobe_n = 1;
  logic        cycle_qualify_n = 1, write_not_read = 1, ready_return_in_n = 1;
  logic [31:0] data_in = 32'h1234_5678, data_out;
  logic [1:0]  data_oe;
  logic        local_target_hit_n, sync_ready_out_n, async_wait_out;
  hbi_req_t    host_req;
  hbi_rsp_t    host_rsp;
  int          compares = 0, miscompares = 0;

  always #5 clk = ~clk;

  hbi_host_bus_unit i_hbi_host_bus_unit (.clk(clk), .rst(rst), .bus_is_32(bus_is_32),
    .bus_type_strap(bus_type_strap), .base_addr(BASE), .host_addr(host_addr), .io_qualify_n(io_qualify_n),
    .byte_lane0_sel_n(be_n[0]), .byte_lane1_sel_n(be_n[1]), .byte_lane2_sel_n(be_n[2]),
    .byte_lane3_sel_n(be_n[3]), .addr_strobe_n(addr_strobe_n), .data_port_select_n(data_port_select_n),
    .async_read_strobe_n(async_read_strobe_n), .async_write_strobe_n(async_write_strobe_n),
    .cycle_qualify_n(cycle_qualify_n), .write_not_read(write_not_read), .ready_return_in_n(ready_return_in_n),
    .data_in(data_in), .data_out(data_out), .data_oe(data_oe), .local_target_hit_n(local_target_hit_n),
    .sync_ready_out_n(sync_ready_out_n), .async_wait_out(async_wait_out), .host_req(host_req),
    .host_rsp(host_rsp));

  hbi_int_model i_hbi_int_model (.clk(clk), .rst(rst), .req(host_req), .delay(4'h3), .word(WORD),
    .rsp(host_rsp));

  task automatic chk_b(input logic got, input logic exp, input string what);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD t=%0t %s got %b exp %b", $time, what, got, exp);
    end
  endtask : chk_b

  task automatic chk_v(input logic [31:0] got, input logic [31:0] exp, input string what);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk_v

  task automatic wrap_up();
    $display("compares=%0d miscompares=%0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : wrap_up

  task automatic do_reset(input logic strap);
    @(negedge clk);
    rst = 1;
    bus_type_strap = strap;
    repeat (16) @(negedge clk);
    chk_v(32'({data_oe, local_target_hit_n, sync_ready_out_n, async_wait_out}), 32'h7, "reset outputs");
    rst = 0;
    repeat (8) @(negedge clk);
  endtask : do_reset

  task automatic wait_req(output hbi_req_t r, output logic seen);
    seen = 0;
    r    = '0;
    // req stands one clock only, so it is looked at between the rising edges
    for (int i = 0; i < 12 && !seen; i++) begin
      if (host_req.req === 1'b1) begin
        seen = 1;
        r    = host_req;
      end else begin
        @(negedge clk);
      end
    end
  endtask : wait_req

  // sel 0 watches sync ready, sel 1 the async wait output
  task automatic wait_out(input int sel, input logic v, input string what);
    logic cur;
    for (int i = 0; i < 20; i++) begin
      @(negedge clk);
      cur = sel ? async_wait_out : sync_ready_out_n;
      if (cur === v) break;
    end
    chk_b(cur, v, what);
  endtask : wait_out

  function automatic logic [31:0] mask(input logic [3:0] l);
    return {{8{l[3]}}, {8{l[2]}}, {8{l[1]}}, {8{l[0]}}};
  endfunction : mask

  task automatic hit_test();
    host_addr = {~BASE, 3'h2};
    repeat (6) @(negedge clk);
    chk_b(local_target_hit_n, 1, "hit on foreign base");
    host_addr = {BASE, 3'h2};
    repeat (6) @(negedge clk);
    chk_b(local_target_hit_n, 0, "no hit on own base");
    io_qualify_n = 1;
    repeat (6) @(negedge clk);
    chk_b(local_target_hit_n, 1, "hit with memory qualifier");
    io_qualify_n = 0;
    addr_strobe_n = 1;
    repeat (6) @(negedge clk);
    host_addr = {~BASE, 3'h2};
    repeat (6) @(negedge clk);
    chk_b(local_target_hit_n, 0, "latch followed pins");
    addr_strobe_n = 0;
    repeat (6) @(negedge clk);
    chk_b(local_target_hit_n, 1, "latch did not reopen");
    host_addr = {BASE, 3'h2};
    repeat (6) @(negedge clk);
  endtask : hit_test

  task automatic vl_cycle(input logic [3:0] be, input logic [3:0] lanes, input logic we);
    hbi_req_t r;
    logic     seen;
    @(negedge clk);
    be_n = be;
    // the latch needs one clock to take the byte enables before qualify
    @(negedge clk);
    write_not_read = we;
    cycle_qualify_n = 0;
    @(negedge clk);
    cycle_qualify_n = 1;
    write_not_read = ~we;
    wait_req(r, seen);
    chk_b(seen, 1, "no request");
    chk_b(r.we, we, "direction");
    chk_v(32'(r.lanes), 32'(lanes), "lanes");
    if (we) chk_v(r.wdata, data_in, "write data");
    wait_out(0, 0, "sync ready");
    if (!we) chk_v(data_out & mask(lanes), WORD & mask(lanes), "read data");
    if (!we) chk_v(32'(data_oe), 32'({bus_is_32, 1'b1}), "read lines not driven");
    if (!bus_is_32) chk_b(data_oe[1], 0, "upper lines driven");
    @(negedge clk);
    chk_b(sync_ready_out_n, 0, "ready dropped before return");
    ready_return_in_n = 0;
    @(negedge clk);
    ready_return_in_n = 1;
    chk_b(sync_ready_out_n, 1, "ready kept after return");
  endtask : vl_cycle

  task automatic narrow_bus();
    hbi_req_t r;
    logic     seen;
    @(negedge clk);
    bus_is_32 = 0;
    be_n = 4'h3;
    @(negedge clk);
    cycle_qualify_n = 0;
    @(negedge clk);
    cycle_qualify_n = 1;
    wait_req(r, seen);
    chk_b(seen, 0, "upper half taken on 16-bit bus");
    vl_cycle(4'hC, 4'h3, 0);
    bus_is_32 = 1;
  endtask : narrow_bus

  task automatic async_dp();
    hbi_req_t r;
    logic     seen;
    @(negedge clk);
    data_port_select_n = 0;
    io_qualify_n = 1;
    be_n = 4'hB;
    repeat (5) @(negedge clk);
    async_write_strobe_n = 0;
    wait_req(r, seen);
    chk_b(seen & r.data_port & r.we, 1, "data port write");
    chk_v(32'(r.lanes), 32'hF, "data port lanes");
    chk_b(async_wait_out, 0, "no async wait");
    wait_out(1, 1, "async wait release");
    async_write_strobe_n = 1;
    data_port_select_n = 1;
    io_qualify_n = 0;
    be_n = 4'hF;
    repeat (8) @(negedge clk);
  endtask : async_dp

  task automatic burst(input logic we);
    hbi_req_t r;
    logic     seen;
    @(negedge clk);
    be_n = 4'h0;
    if (we) cycle_qualify_n = 0;
    else write_not_read = 0;
    ready_return_in_n = 0;
    wait_req(r, seen);
    chk_b(seen, 1, "no burst request");
    chk_b(r.we, we, "burst direction");
    chk_b(sync_ready_out_n, 1, "ready before data done");
    @(negedge clk);
    cycle_qualify_n = 1;
    write_not_read = 1;
    wait_out(0, 0, "burst ready");
    if (!we) chk_v(data_out, WORD, "burst read data");
    repeat (3) @(negedge clk);
    chk_b(sync_ready_out_n, 0, "host wait ignored");
    ready_return_in_n = 1;
    @(negedge clk);
    chk_b(sync_ready_out_n, 1, "beat not ended");
    repeat (6) @(negedge clk);
  endtask : burst

  localparam logic [3:0] BES [7] = '{4'hE, 4'hD, 4'hB, 4'h7, 4'hC, 4'h3, 4'h0};
  localparam logic [3:0] LNS [7] = '{4'h1, 4'h2, 4'h4, 4'h8, 4'h3, 4'hC, 4'hF};

  initial begin
    do_reset(0);
    hit_test();
    for (int i = 0; i < 7; i++) begin
      vl_cycle(BES[i], LNS[i], i[0]);
    end
    narrow_bus();
    async_dp();
    do_reset(1);
    burst(1);
    burst(0);
    wrap_up();
  end

  // the sequence needs well under 2000 cycles
  initial begin
    #50000;
    miscompares++;
    $display("BAD t=%0t watchdog expired", $time);
    wrap_up();
  end
endmodule : tb
`default_nettype wire
